/* File: common/audio_port_routing_config_map.svh */
// Offsets, field positions, reset values and codes of the audio port routing registers.
// Assumes it is included by its bare name from design files that need the map.
`ifndef AUDIO_PORT_ROUTING_CONFIG_MAP_SVH
`define AUDIO_PORT_ROUTING_CONFIG_MAP_SVH

`define PIN_TRIG_OFS      8'h15
`define PORT_EN_OFS       8'h18
`define LANE_CFG_OFS      8'h19

`define PIN_TRIG_RST      8'h00
`define PORT_EN_RST       8'h40
`define LANE_CFG_RST      8'h00

`define PIN_TRIG_WMASK    8'hF0
`define PORT_EN_WMASK     8'hFF
`define LANE_CFG_WMASK    8'hF8

`define BIAS_SEL_HI       7
`define BIAS_SEL_LO       6
`define CONV_SEL_HI       5
`define CONV_SEL_LO       4
`define PRI_DIS_BIT       7
`define SEC_DIS_BIT       6
`define GANG_BIT          5
`define CHAIN_EN_HI       4
`define CHAIN_EN_LO       3
`define CHAIN_IN_HI       2
`define CHAIN_IN_LO       0
`define OUT_LANE_HI       7
`define OUT_LANE_LO       6
`define IN_LANE_HI        5
`define IN_LANE_LO        4
`define CHAIN_DIR_BIT     3

`define CHAIN_IN_OFF      3'h0
`define CHAIN_IN_GP1      3'h1
`define CHAIN_IN_GP2      3'h2
`define CHAIN_IN_INONLY   3'h3
`define CHAIN_IN_SDIN     3'h5

`define LANE_SPLIT        2'h0
`define LANE_PRIMARY      2'h1
`define LANE_SECONDARY    2'h2

`endif

/* File: common/audio_port_routing_pkg.sv */
// Types shared by the audio port routing configuration block.
// Assumes the constants come from audio_port_routing_config_map.svh.
package audio_port_routing_pkg;

  // Chain enable codes in their encoded order; the last one is reserved.
  typedef enum logic [1:0] {
    CHAIN_OFF,
    CHAIN_PRIMARY,
    CHAIN_SECONDARY,
    CHAIN_RESERVED
  } chain_mode_t;

  typedef struct packed {
    logic [7:0] pinTrig;
    logic [7:0] portEn;
    logic [7:0] laneCfg;
    logic [7:0] rdData;
    logic       rdValid;
    logic       convPrev;
    logic       biasEn;
    logic       convStart;
    logic       chainData;
    logic       chainActive;
    logic       chainOnInput;
    logic       primaryActive;
    logic       secondaryActive;
    logic       secondaryFollows;
    logic       primaryDualOut;
    logic       secondaryDualOut;
    logic       primaryDualIn;
    logic       secondaryDualIn;
  } state_t;

endpackage

/* File: rtl/audio_port_routing_config.sv */
// Configuration registers that route the audio serial ports and pin triggers.
// Assumes the control port has already been decoded into byte-wide register
// reads and writes, and that all pin inputs are synchronous to clk.
//
// Overview of operation
// - Bits 7-6 choose bias enable pin.
// - Bits 5-4 choose converter start pin.
// - Reserved bits read zero, write reset value.
// - Bit 7 set disables primary port.
// - Bit 6 disables secondary port, resets set.
// - Gang bit makes secondary copy primary settings.
// - Bits 4-3 pick chaining port or off.
// - Chaining allows one port, single lanes.
// - Bits 2-0 pick chained data source.
// - Bits 7-6 assign data output lanes.
// - Bits 5-4 assign data input lanes.
// - Bit 3 chains input or output path.
`timescale 1ns/1ps
`include "audio_port_routing_config_map.svh"

module audio_port_routing_config (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       regWrEn,
  input  wire logic       regRdEn,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  output logic      [7:0] regRdData,
  output logic            regRdValid,
  input  wire logic       generalPinOne,
  input  wire logic       generalPinTwo,
  input  wire logic       inputOnlyPinOne,
  input  wire logic       serialDataIn,
  input  wire logic       biasEnableCtl,
  input  wire logic       convStartReq,
  output logic            microphoneBiasEn,
  output logic            converterStart,
  output logic            chainDataIn,
  output logic            chainActive,
  output logic            chainOnInput,
  output logic            primaryPortActive,
  output logic            secondaryPortActive,
  output logic            secondaryFollowsPrimary,
  output logic            primaryDualOut,
  output logic            secondaryDualOut,
  output logic            primaryDualIn,
  output logic            secondaryDualIn
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  function automatic logic pickPin(input logic [1:0] sel, input logic p1, input logic p2, input logic p3);
    logic lvl;
    lvl = 1'b0;
    unique case (sel)
      2'h1:    lvl = p1;
      2'h2:    lvl = p2;
      2'h3:    lvl = p3;
      default: lvl = 1'b0;
    endcase
    return lvl;
  endfunction

  audio_port_routing_pkg::state_t state_r;
  audio_port_routing_pkg::state_t state_nxt;
  audio_port_routing_pkg::chain_mode_t chainMode;
  logic [1:0] biasSel;
  logic [1:0] convSel;
  logic [2:0] chainSel;
  logic [1:0] outLane;
  logic [1:0] inLane;
  logic       convLvl;
  logic       chainOn;

  assign biasSel  = state_r.pinTrig[`BIAS_SEL_HI:`BIAS_SEL_LO];
  assign convSel  = state_r.pinTrig[`CONV_SEL_HI:`CONV_SEL_LO];
  assign chainSel = state_r.portEn[`CHAIN_IN_HI:`CHAIN_IN_LO];
  assign outLane  = state_r.laneCfg[`OUT_LANE_HI:`OUT_LANE_LO];
  assign inLane   = state_r.laneCfg[`IN_LANE_HI:`IN_LANE_LO];
  assign chainMode = audio_port_routing_pkg::chain_mode_t'(state_r.portEn[`CHAIN_EN_HI:`CHAIN_EN_LO]);
  // The reserved chain code is treated as chaining off so a stray write cannot strand both ports.
  assign chainOn  = (chainMode == audio_port_routing_pkg::CHAIN_PRIMARY) ||
                    (chainMode == audio_port_routing_pkg::CHAIN_SECONDARY);
  assign convLvl  = pickPin(convSel, generalPinOne, generalPinTwo, inputOnlyPinOne);

  ////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    state_nxt = state_r;
    state_nxt.rdValid = regRdEn;
    state_nxt.rdData  = 8'h00;
    if (regRdEn) begin
      unique case (regAddr)
        `PIN_TRIG_OFS: state_nxt.rdData = state_r.pinTrig;
        `PORT_EN_OFS:  state_nxt.rdData = state_r.portEn;
        `LANE_CFG_OFS: state_nxt.rdData = state_r.laneCfg;
        default:       state_nxt.rdData = 8'h00;
      endcase
    end
    // Reserved bits are never stored, so they always read back as zero.
    if (regWrEn) begin
      unique case (regAddr)
        `PIN_TRIG_OFS: state_nxt.pinTrig = regWrData & `PIN_TRIG_WMASK;
        `PORT_EN_OFS:  state_nxt.portEn  = regWrData & `PORT_EN_WMASK;
        `LANE_CFG_OFS: state_nxt.laneCfg = regWrData & `LANE_CFG_WMASK;
        default:       state_nxt.portEn  = state_r.portEn;
      endcase
    end

    // A pin adds to the register control; a disabled select leaves only the register.
    state_nxt.biasEn = biasEnableCtl | pickPin(biasSel, generalPinOne, generalPinTwo, inputOnlyPinOne);
    state_nxt.convPrev  = convLvl;
    // Changing the select can produce one spurious start if the new pin is already high.
    state_nxt.convStart = convStartReq | (convLvl & ~state_r.convPrev);

    unique case (chainSel)
      `CHAIN_IN_GP1:  state_nxt.chainData = generalPinOne;
      `CHAIN_IN_GP2:  state_nxt.chainData = generalPinTwo;
      `CHAIN_IN_INONLY: state_nxt.chainData = inputOnlyPinOne;
      `CHAIN_IN_SDIN: state_nxt.chainData = serialDataIn;
      default:        state_nxt.chainData = 1'b0;
    endcase

    state_nxt.chainActive  = chainOn;
    state_nxt.chainOnInput = chainOn & state_r.laneCfg[`CHAIN_DIR_BIT];
    state_nxt.primaryActive = ~state_r.portEn[`PRI_DIS_BIT] &
                              (chainMode != audio_port_routing_pkg::CHAIN_SECONDARY);
    state_nxt.secondaryActive = ~state_r.portEn[`SEC_DIS_BIT] &
                                (chainMode != audio_port_routing_pkg::CHAIN_PRIMARY);
    state_nxt.secondaryFollows = state_r.portEn[`GANG_BIT];
    // Chaining forces one data output and one data input per port.
    state_nxt.primaryDualOut   = ~chainOn & (outLane == `LANE_PRIMARY);
    state_nxt.secondaryDualOut = ~chainOn & (outLane == `LANE_SECONDARY);
    state_nxt.primaryDualIn    = ~chainOn & (inLane == `LANE_PRIMARY);
    state_nxt.secondaryDualIn  = ~chainOn & (inLane == `LANE_SECONDARY);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r         <= '0;
      state_r.pinTrig <= `PIN_TRIG_RST;
      state_r.portEn  <= `PORT_EN_RST;
      state_r.laneCfg <= `LANE_CFG_RST;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign regRdData               = state_r.rdData;
  assign regRdValid              = state_r.rdValid;
  assign microphoneBiasEn        = state_r.biasEn;
  assign converterStart          = state_r.convStart;
  assign chainDataIn             = state_r.chainData;
  assign chainActive             = state_r.chainActive;
  assign chainOnInput            = state_r.chainOnInput;
  assign primaryPortActive       = state_r.primaryActive;
  assign secondaryPortActive     = state_r.secondaryActive;
  assign secondaryFollowsPrimary = state_r.secondaryFollows;
  assign primaryDualOut          = state_r.primaryDualOut;
  assign secondaryDualOut        = state_r.secondaryDualOut;
  assign primaryDualIn           = state_r.primaryDualIn;
  assign secondaryDualIn         = state_r.secondaryDualIn;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  reserved_zero_a: assert property (@(posedge clk) disable iff (rst)
    (state_r.pinTrig[3:0] == 4'h0) && (state_r.laneCfg[2:0] == 3'h0))
    else $error("Reserved register bits hold a nonzero value.");

  bias_pin_off_a: assert property (@(posedge clk) disable iff (rst)
    (biasSel == 2'h0) ##1 (biasSel == 2'h0) |-> microphoneBiasEn == $past(biasEnableCtl))
    else $error("Bias enable followed a pin while pin control was off.");

  bias_pin_one_a: assert property (@(posedge clk) disable iff (rst)
    (biasSel == 2'h1) && generalPinOne |=> microphoneBiasEn)
    else $error("Bias enable missed the selected general pin.");

  conv_start_edge_a: assert property (@(posedge clk) disable iff (rst)
    (convSel == 2'h3) && (convSel == $past(convSel)) && $rose(inputOnlyPinOne) |=> converterStart)
    else $error("Converter start missed a rising edge on the selected pin.");

  conv_pin_off_a: assert property (@(posedge clk) disable iff (rst)
    (convSel == 2'h0) && !convStartReq |=> !converterStart)
    else $error("Converter start fired with pin start disabled and no request.");

  chain_one_port_a: assert property (@(posedge clk) disable iff (rst)
    chainActive |-> !(primaryPortActive && secondaryPortActive) && !primaryDualOut && !secondaryDualOut
                    && !primaryDualIn && !secondaryDualIn)
    else $error("Chaining left two ports or a dual lane active.");

  port_disable_a: assert property (@(posedge clk) disable iff (rst)
    regWrEn && (regAddr == `PORT_EN_OFS) && regWrData[`PRI_DIS_BIT] |-> ##2 !primaryPortActive)
    else $error("Primary port stayed active after its disable was written.");

  sec_disable_a: assert property (@(posedge clk) disable iff (rst)
    regWrEn && (regAddr == `PORT_EN_OFS) && regWrData[`SEC_DIS_BIT] |-> ##2 !secondaryPortActive)
    else $error("Secondary port stayed active after its disable was written.");

  chain_src_off_a: assert property (@(posedge clk) disable iff (rst)
    (chainSel == `CHAIN_IN_OFF) |=> !chainDataIn)
    else $error("Chained data moved while the chain input was disabled.");

  chain_src_sdin_a: assert property (@(posedge clk) disable iff (rst)
    (chainSel == `CHAIN_IN_SDIN) |=> chainDataIn == $past(serialDataIn))
    else $error("Chained data did not follow the serial data input.");

  gang_follow_a: assert property (@(posedge clk) disable iff (rst)
    secondaryFollowsPrimary == $past(state_r.portEn[`GANG_BIT]))
    else $error("Secondary gang output does not match the gang bit.");

  unmapped_read_a: assert property (@(posedge clk) disable iff (rst)
    regRdEn && (regAddr != `PIN_TRIG_OFS) && (regAddr != `PORT_EN_OFS) && (regAddr != `LANE_CFG_OFS)
    |=> regRdValid && (regRdData == 8'h00))
    else $error("Unmapped read returned nonzero data.");

endmodule

/* File: tb/audio_port_host_model.sv */
// Host model that drives the decoded register port of the routing block.
// Assumes the bench calls its tasks one transfer at a time, from one process.
`timescale 1ns/1ps
`include "audio_port_routing_config_map.svh"
module audio_port_host_model (
  input  wire logic       clk,
  output logic            regWrEn,
  output logic            regRdEn,
  output logic      [7:0] regAddr,
  output logic      [7:0] regWrData,
  input  wire logic [7:0] regRdData,
  input  wire logic       regRdValid
);
  initial begin
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
  end
  //////////////////////////////////////////////////////////////////////////////
  // Reserved bits are cleared here, so no caller can upset them by accident.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= (a == `PIN_TRIG_OFS) ? d & `PIN_TRIG_WMASK : (a == `LANE_CFG_OFS) ? d & `LANE_CFG_WMASK : d;
    regWrEn <= 1'b1;
    @(posedge clk);
    regWrEn <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk);
    regRdEn <= 1'b0;
    #1;
    d = regRdData;
    v = regRdValid;
  endtask
endmodule

/* File: tb/audio_port_routing_config_bench.sv */
// Self-checking bench for the audio port routing configuration registers.
// Assumes the host model owns the register port and the bench owns the pins.
`timescale 1ns/1ps
`include "audio_port_routing_config_map.svh"
module audio_port_routing_config_bench;
  logic clk, rst, regWrEn, regRdEn, regRdValid, serialDataIn, biasEnableCtl, convStartReq;
  logic [7:0] regAddr, regWrData, regRdData;
  logic [2:0] pins;
  logic microphoneBiasEn, converterStart, chainDataIn, chainActive, chainOnInput, primaryPortActive;
  logic secondaryPortActive, secondaryFollowsPrimary, primaryDualOut, secondaryDualOut, primaryDualIn, secondaryDualIn;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [3:0] src;
  audio_port_host_model u_audio_port_host_model (.clk, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData,
    .regRdValid);
  audio_port_routing_config u_audio_port_routing_config (.clk, .rst, .regWrEn, .regRdEn, .regAddr, .regWrData,
    .regRdData, .regRdValid, .generalPinOne(pins[0]), .generalPinTwo(pins[1]), .inputOnlyPinOne(pins[2]),
    .serialDataIn, .biasEnableCtl, .convStartReq, .microphoneBiasEn, .converterStart, .chainDataIn, .chainActive,
    .chainOnInput, .primaryPortActive, .secondaryPortActive, .secondaryFollowsPrimary, .primaryDualOut,
    .secondaryDualOut, .primaryDualIn, .secondaryDualIn);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // The whole run needs about 330 cycles, so this ceiling only catches a hang.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      errors++;
      results();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic v;
    u_audio_port_host_model.rd(a, d, v);
    check("rdValid", v, 8'h01);
    check("rdData", d, e);
  endtask
  task automatic settle;
    @(posedge clk);
    #1;
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    pins = 3'h0;
    serialDataIn = 1'b0;
    biasEnableCtl = 1'b0;
    convStartReq = 1'b0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    settle();
    check("priActive", primaryPortActive, 8'h01);
    check("secActive", secondaryPortActive, 8'h00);
    rdchk(`PIN_TRIG_OFS, `PIN_TRIG_RST);
    rdchk(`PORT_EN_OFS, `PORT_EN_RST);
    rdchk(`LANE_CFG_OFS, `LANE_CFG_RST);
    $display("test reset done");
    for (int s = 0; s < 4; s++) begin
      u_audio_port_host_model.wr(`PIN_TRIG_OFS, {s[1:0], s[1:0], 4'hF});
      rdchk(`PIN_TRIG_OFS, {s[1:0], s[1:0], 4'h0});
      for (int k = 1; k < 4; k++) begin
        @(posedge clk);
        pins <= 3'h1 << (k - 1);
        settle();
        check("bias", microphoneBiasEn, 8'(s == k));
        check("conv", converterStart, 8'(s == k));
        @(posedge clk);
        pins <= 3'h0;
        repeat (2) @(posedge clk);
      end
    end
    u_audio_port_host_model.wr(`PIN_TRIG_OFS, 8'h00);
    biasEnableCtl <= 1'b1;
    convStartReq <= 1'b1;
    @(posedge clk);
    convStartReq <= 1'b0;
    biasEnableCtl <= 1'b0;
    #1;
    check("biasCtl", microphoneBiasEn, 8'h01);
    check("convReq", converterStart, 8'h01);
    $display("test pins done");
    for (int c = 0; c < 8; c++) begin
      u_audio_port_host_model.wr(`PORT_EN_OFS, {5'h08, c[2:0]});
      for (int p = 0; p < 2; p++) begin
        @(posedge clk);
        src = p ? 4'hA : 4'h5;
        pins <= src[2:0];
        serialDataIn <= src[3];
        settle();
        settle();
        check("chainIn", chainDataIn, 8'((c == 1 && src[0]) || (c == 2 && src[1]) || (c == 3 && src[2])
          || (c == 5 && src[3])));
      end
    end
    $display("test chain source done");
    for (int m = 0; m < 3; m++) begin
      for (int d = 0; d < 4; d++) begin
        u_audio_port_host_model.wr(`PORT_EN_OFS, {d[1:0], d[0], m[1:0], 3'h0});
        rdchk(`PORT_EN_OFS, {d[1:0], d[0], m[1:0], 3'h0});
        for (int o = 0; o < 3; o++) begin
          u_audio_port_host_model.wr(`LANE_CFG_OFS, {o[1:0], 2'(2 - o), o[0], 3'h0});
          settle();
          check("priActive", primaryPortActive, 8'(!d[1] && m != 2));
          check("secActive", secondaryPortActive, 8'(!d[0] && m != 1));
          check("follows", secondaryFollowsPrimary, 8'(d[0]));
          check("chainActive", chainActive, 8'(m != 0));
          check("chainOnInput", chainOnInput, 8'(m != 0 && o[0]));
          check("priDualOut", primaryDualOut, 8'(m == 0 && o == 1));
          check("secDualOut", secondaryDualOut, 8'(m == 0 && o == 2));
          check("priDualIn", primaryDualIn, 8'(m == 0 && o == 1));
          check("secDualIn", secondaryDualIn, 8'(m == 0 && o == 0));
        end
      end
    end
    $display("test modes done");
    u_audio_port_host_model.wr(8'h16, 8'hFF);
    rdchk(8'h16, 8'h00);
    rdchk(`LANE_CFG_OFS, 8'h80);
    rdchk(`PORT_EN_OFS, 8'hF0);
    $display("test unmapped done");
    // A second reset in mid-run must bring back the reset values over a changed setup.
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    settle();
    check("priActive", primaryPortActive, 8'h01);
    check("secActive", secondaryPortActive, 8'h00);
    rdchk(`PORT_EN_OFS, `PORT_EN_RST);
    rdchk(`LANE_CFG_OFS, `LANE_CFG_RST);
    $display("test second reset done");
    results();
  end
endmodule
